// File: kbh_fifo2.sv
// two-entry byte buffer between link crossing and scan reporting
module kbh_fifo2 (
   input wire logic clk,      // core clock
   input wire logic rst_n,    // asynchronous reset, active low
   kbh_stream_if.snk wr,      // filling side
   kbh_stream_if.src rd       // draining side
);
   kbh_pkg::kbh_byte_t mem [2];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   assign wr.ready = (cnt_q != 2'h2);
   assign rd.valid = (cnt_q != 2'h0);
   assign rd.data = mem[rp_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   property p_no_overflow;
      @(posedge clk) disable iff (!rst_n)
      (cnt_q == 2'h2 && !pop) |=> cnt_q == 2'h2 && $stable(wp_q);
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("buffer lost or gained an entry while full");

   c_full: cover property (@(posedge clk) disable iff (!rst_n)
      cnt_q == 2'h2);
endmodule

// File: kbh_kbd_model.sv
// keyboard model on the open-collector clock and data link
module kbh_kbd_model (
   input wire logic clk_w, // clock wire level
   input wire logic dat_w, // data wire level
   output logic clk_d,     // clock drive, 0 pulls low
   output logic dat_d      // data drive, 0 pulls low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got;
   initial begin
      clk_d = 1'b1;
      dat_d = 1'b1;
      got = 8'h00;
   end
   // ------------------------------------------------------------
   // keyboard to host frame, 64 ns per bit
   // ------------------------------------------------------------
   task automatic tx(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ~^b, b, 1'b0};
      wait (clk_w === 1'b1); // an inhibit holds the frame back
      for (int i = 0; i < 11; i++) begin
         dat_d = f[i];
         #32 clk_d = 1'b0;
         #32 clk_d = 1'b1;
      end
      dat_d = 1'b1;
   endtask
   // slow clock so the synchronised host side can follow
   task automatic rx(input logic ack);
      for (int i = 0; i < 11; i++) begin
         // ack settles well before its fall so the synchronised host sees it
         if (i == 10) dat_d = ~ack;
         #400;
         if (i > 0 && i < 9) got = {dat_w, got[7:1]};
         clk_d = 1'b0;
         #400 clk_d = 1'b1;
      end
      dat_d = 1'b1;
   endtask
endmodule

// File: kbh_link.sv
// keyboard-to-host frame receiver running on the keyboard clock
`include "kbh_regs.svh"
module kbh_link (
   input wire logic kb_clk,              // keyboard clock pin, link domain
   input wire logic rst_n,               // asynchronous reset, active low
   input wire logic kb_dat,              // keyboard data pin
   output kbh_pkg::kbh_byte_t rx_byte_q, // last good byte, held
   output logic rx_tgl_q                 // flips once per good frame
);
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic par_ok_q;

   // ----------------------------------------------------------------------
   // frame shifter, sampled on falling edges
   // ----------------------------------------------------------------------
   // the clock stops between frames, so the frame ends on its stop edge
   always_ff @(negedge kb_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         par_ok_q <= 1'b0;
         rx_byte_q <= 8'h00;
         rx_tgl_q <= 1'b0;
      end else if (cnt_q == 4'h0) begin
         if (!kb_dat) begin
            cnt_q <= 4'h1;
         end
      end else if (cnt_q <= 4'h8) begin
         sh_q <= {kb_dat, sh_q[7:1]};
         cnt_q <= cnt_q + 4'h1;
      end else if (cnt_q == 4'h9) begin
         par_ok_q <= (^sh_q) ^ kb_dat;
         cnt_q <= 4'ha;
      end else begin
         cnt_q <= 4'h0;
         if (kb_dat && par_ok_q) begin
            rx_byte_q <= sh_q;
            rx_tgl_q <= ~rx_tgl_q;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_frame_good;
      @(negedge kb_clk) disable iff (!rst_n)
      (cnt_q == 4'ha && kb_dat && par_ok_q) |=>
         (rx_tgl_q != $past(rx_tgl_q)) && (rx_byte_q == $past(sh_q));
   endproperty
   a_frame_good: assert property (p_frame_good)
      else $error("good frame did not deliver its byte");

   property p_frame_bad;
      @(negedge kb_clk) disable iff (!rst_n)
      (cnt_q == 4'ha && !(kb_dat && par_ok_q)) |=> $stable(rx_tgl_q);
   endproperty
   a_frame_bad: assert property (p_frame_bad)
      else $error("broken frame was delivered");

   c_frame: cover property (@(negedge kb_clk) disable iff (!rst_n)
      cnt_q == 4'ha && kb_dat && par_ok_q);
endmodule

// File: kbh_pkg.sv
// shared types of the keyboard host
package kbh_pkg;
   typedef logic [7:0] kbh_byte_t;
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_INHIBIT,
      TX_BITS,
      TX_ACK,
      TX_DONE
   } kbh_tx_e;
endpackage

// File: kbh_regs.svh
// register map, field positions, reset values and timing of the keyboard host
`ifndef KBH_REGS_SVH
`define KBH_REGS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define KBH_CMD_ADDR 32'hfff8_9000
`define KBH_STS_ADDR 32'hfff8_9004
`define KBH_SCAN_ADDR 32'hffff_9008

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define KBH_CMD_RST 32'h0000_0000
`define KBH_STS_RST 32'h0000_0000
`define KBH_SCAN_RST 32'h0000_0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define KBH_CMD_TRAP_BIT 9
`define KBH_CMD_START_BIT 8
`define KBH_STS_TXERR_BIT 5
`define KBH_STS_TXIRQ_BIT 4
`define KBH_STS_RXIRQ_BIT 0
`define KBH_SCAN_SHIFT_BIT 10
`define KBH_SCAN_REL_BIT 9
`define KBH_SCAN_EXT_BIT 8

// ----------------------------------------------------------------------
// key codes
// ----------------------------------------------------------------------
`define KBH_CODE_EXT 8'he0
`define KBH_CODE_REL 8'hf0
`define KBH_CODE_LSHIFT 8'h12
`define KBH_CODE_RSHIFT 8'h59

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define KBH_CLK_NS 40
`define KBH_INHIBIT_US 60
`define KBH_FRAME_BITS 11

`endif

// File: kbh_stream_if.sv
// byte stream with valid and ready between the receive stages
interface kbh_stream_if;
   logic valid;
   logic ready;
   kbh_pkg::kbh_byte_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: kbh_top.sv
// keyboard host status, scan-code reporting and command sender
//
// Contract
// - transmit error flag, status bit 5, set on missing acknowledge, read only
// - transmit error flag clears when the next command send starts
// - receive flag, status bit 0, set when a byte reaches scan register
// - extend and release prefix bytes raise no receive interrupt
// - prefix bytes never overwrite the received byte field
// - shift trap bit decides whether shift codes report and interrupt
// - shift-held flag, scan bit 10, set on press, cleared on release
// - release-seen flag, scan bit 9, set by F0, redone on next reported byte
// - extend-seen flag, scan bit 8, set by E0, redone on next reported byte
// - raw received byte held in scan register bits 7 to 0
// - trapped shift codes only update the shift-held flag, no report
// - command-start bit launches a send and hardware clears it after
// - frames are 11 bits: start, 8 data lsb first, odd parity, stop
`include "kbh_regs.svh"
module kbh_top (
   input wire logic CORE_CLK,      // core clock, 25 MHz
   input wire logic RESET_N,       // asynchronous reset, active low
   input wire logic PSEL,          // register bus select
   input wire logic PENABLE,       // register bus access phase
   input wire logic PWRITE,        // register bus write
   input wire logic [31:0] PADDR,  // register bus address
   input wire logic [31:0] PWDATA, // register bus write data
   output logic [31:0] PRDATA,     // register bus read data
   output logic IRQ,               // interrupt request, active high
   input wire logic KB_CLK_I,      // keyboard clock pin level, link clock
   output logic KB_CLK_O,          // keyboard clock drive value
   output logic KB_CLK_OE_N,       // keyboard clock drive enable, active low
   input wire logic KB_DAT_I,      // keyboard data pin level
   output logic KB_DAT_O,          // keyboard data drive value
   output logic KB_DAT_OE_N        // keyboard data drive enable, active low
);
   localparam int InhCyc =
      (`KBH_INHIBIT_US * 1000 + `KBH_CLK_NS - 1) / `KBH_CLK_NS;
   localparam logic [10:0] InhLoad = 11'(InhCyc - 1);

   kbh_pkg::kbh_tx_e st_q;
   logic [10:0] inh_cnt_q;
   logic [3:0] fall_cnt_q;
   logic [7:0] cmd_byte_q;
   logic trap_q, cmd_start_q;
   logic tx_err_q, tx_irq_q, rx_irq_q, tx_irq_d, rx_irq_d;
   logic [7:0] scan_q;
   logic ext_q, rel_q, shift_q, seen_ext_q, seen_rel_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic kclk_s1_q, kclk_s2_q, kclk_s3_q, kclk_f_q;
   logic kdat_s1_q, kdat_s2_q, kdat_s3_q, kdat_f_q;
   logic tgl_s1_q, tgl_s2_q, tgl_s3_q, tgl_seen_q;
   logic pend_q, rx_inh_q;
   logic [7:0] pend_byte_q;
   logic clk_o_q, clk_oe_n_q, dat_o_q, dat_oe_n_q;
   logic kclk_fall, rx_evt, wr_en, rd_en, tx_launch, tx_finish;
   logic drain, is_ext, is_rel, is_shift, trapped;
   logic sts_wr, cmd_wr;
   kbh_pkg::kbh_byte_t link_byte;
   logic link_tgl;

   kbh_stream_if buf_wr ();
   kbh_stream_if buf_rd ();

   kbh_link u_link (
      .kb_clk(KB_CLK_I),
      .rst_n(RESET_N),
      .kb_dat(KB_DAT_I),
      .rx_byte_q(link_byte),
      .rx_tgl_q(link_tgl)
   );

   kbh_fifo2 u_fifo (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .wr(buf_wr),
      .rd(buf_rd)
   );

   // ----------------------------------------------------------------------
   // pin and crossing synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {kclk_s1_q, kclk_s2_q, kclk_s3_q, kclk_f_q} <= 4'hf;
         {kdat_s1_q, kdat_s2_q, kdat_s3_q, kdat_f_q} <= 4'hf;
         {tgl_s1_q, tgl_s2_q, tgl_s3_q} <= 3'h0;
      end else begin
         {kclk_s1_q, kclk_s2_q, kclk_s3_q} <=
            {KB_CLK_I, kclk_s1_q, kclk_s2_q};
         {kdat_s1_q, kdat_s2_q, kdat_s3_q} <=
            {KB_DAT_I, kdat_s1_q, kdat_s2_q};
         {tgl_s1_q, tgl_s2_q, tgl_s3_q} <= {link_tgl, tgl_s1_q, tgl_s2_q};
         if (kclk_s2_q == kclk_s3_q) kclk_f_q <= kclk_s3_q;
         if (kdat_s2_q == kdat_s3_q) kdat_f_q <= kdat_s3_q;
      end
   end

   assign kclk_fall = kclk_f_q && !kclk_s2_q && !kclk_s3_q;
   // the link byte is quiet for a whole frame after its toggle moves
   assign rx_evt = (tgl_s2_q == tgl_s3_q) && (tgl_s3_q != tgl_seen_q);

   // ----------------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------------
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_en = PSEL && !PENABLE && !PWRITE;
   assign cmd_wr = wr_en && (PADDR == `KBH_CMD_ADDR);
   assign sts_wr = wr_en && (PADDR == `KBH_STS_ADDR);

   // read data is loaded in the setup phase so it stands in the access phase
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_q <= 32'h0000_0000;
         if (PADDR == `KBH_CMD_ADDR) begin
            prdata_q[7:0] <= cmd_byte_q;
            prdata_q[`KBH_CMD_START_BIT] <= cmd_start_q;
            prdata_q[`KBH_CMD_TRAP_BIT] <= trap_q;
         end else if (PADDR == `KBH_STS_ADDR) begin
            prdata_q[`KBH_STS_TXERR_BIT] <= tx_err_q;
            prdata_q[`KBH_STS_TXIRQ_BIT] <= tx_irq_q;
            prdata_q[`KBH_STS_RXIRQ_BIT] <= rx_irq_q;
         end else if (PADDR == `KBH_SCAN_ADDR) begin
            prdata_q[7:0] <= scan_q;
            prdata_q[`KBH_SCAN_EXT_BIT] <= ext_q;
            prdata_q[`KBH_SCAN_REL_BIT] <= rel_q;
            prdata_q[`KBH_SCAN_SHIFT_BIT] <= shift_q;
         end
      end
   end

   // ----------------------------------------------------------------------
   // command register
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd_byte_q <= 8'(`KBH_CMD_RST);
         trap_q <= 1'b0;
         cmd_start_q <= 1'b0;
      end else begin
         if (cmd_wr) begin
            trap_q <= PWDATA[`KBH_CMD_TRAP_BIT];
         end
         if (tx_finish) begin
            cmd_start_q <= 1'b0;
         end else if (cmd_wr && !cmd_start_q) begin
            // byte and start are locked while a send is running
            cmd_byte_q <= PWDATA[7:0];
            cmd_start_q <= PWDATA[`KBH_CMD_START_BIT];
         end
      end
   end

   // ----------------------------------------------------------------------
   // command sender
   // ----------------------------------------------------------------------
   assign tx_launch = (st_q == kbh_pkg::TX_IDLE) && cmd_start_q;
   assign tx_finish = (st_q == kbh_pkg::TX_DONE) && kclk_f_q;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= kbh_pkg::TX_IDLE;
         inh_cnt_q <= 11'h000;
         fall_cnt_q <= 4'h0;
         dat_o_q <= 1'b1;
         dat_oe_n_q <= 1'b1;
      end else begin
         case (st_q)
            kbh_pkg::TX_IDLE: begin
               if (tx_launch) begin
                  inh_cnt_q <= InhLoad;
                  st_q <= kbh_pkg::TX_INHIBIT;
               end
            end
            kbh_pkg::TX_INHIBIT: begin
               if (inh_cnt_q == 11'h000) begin
                  dat_o_q <= 1'b0;
                  dat_oe_n_q <= 1'b0;
                  fall_cnt_q <= 4'h0;
                  st_q <= kbh_pkg::TX_BITS;
               end else begin
                  inh_cnt_q <= inh_cnt_q - 11'h001;
               end
            end
            kbh_pkg::TX_BITS: begin
               if (kclk_fall) begin
                  fall_cnt_q <= fall_cnt_q + 4'h1;
                  if (fall_cnt_q < 4'h8) begin
                     dat_o_q <= cmd_byte_q[fall_cnt_q[2:0]];
                     dat_oe_n_q <= cmd_byte_q[fall_cnt_q[2:0]];
                  end else if (fall_cnt_q == 4'h8) begin
                     dat_o_q <= ~^cmd_byte_q;
                     dat_oe_n_q <= ~^cmd_byte_q;
                  end else begin
                     dat_o_q <= 1'b1;
                     dat_oe_n_q <= 1'b1;
                     st_q <= kbh_pkg::TX_ACK;
                  end
               end
            end
            kbh_pkg::TX_ACK: begin
               if (kclk_fall) begin
                  st_q <= kbh_pkg::TX_DONE;
               end
            end
            kbh_pkg::TX_DONE: begin
               // waiting for the clock to rise keeps the ack frame out
               if (kclk_f_q) begin
                  st_q <= kbh_pkg::TX_IDLE;
               end
            end
            default: st_q <= kbh_pkg::TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_err_q <= 1'b0;
      end else if (tx_launch) begin
         tx_err_q <= 1'b0;
      end else if (st_q == kbh_pkg::TX_ACK && kclk_fall) begin
         tx_err_q <= kdat_f_q;
      end
   end

   // ----------------------------------------------------------------------
   // receive path: crossing, hold and back-pressure
   // ----------------------------------------------------------------------
   assign buf_wr.valid = pend_q;
   assign buf_wr.data = pend_byte_q;

   // a full buffer with a byte waiting in the hold register holds the keyboard clock low so it keeps its next frame
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tgl_seen_q <= 1'b0;
         pend_q <= 1'b0;
         pend_byte_q <= 8'h00;
         rx_inh_q <= 1'b0;
      end else begin
         if (rx_evt) tgl_seen_q <= tgl_s3_q;
         if (rx_evt && st_q == kbh_pkg::TX_IDLE) begin
            pend_q <= 1'b1;
            pend_byte_q <= link_byte;
         end else if (buf_wr.ready) begin
            pend_q <= 1'b0;
         end
         rx_inh_q <= pend_q && !buf_wr.ready;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         clk_o_q <= 1'b1;
         clk_oe_n_q <= 1'b1;
      end else begin
         clk_o_q <= !(st_q == kbh_pkg::TX_INHIBIT || rx_inh_q);
         clk_oe_n_q <= !(st_q == kbh_pkg::TX_INHIBIT || rx_inh_q);
      end
   end

   // ----------------------------------------------------------------------
   // scan reporting
   // ----------------------------------------------------------------------
   assign buf_rd.ready = !rx_irq_q;
   assign drain = buf_rd.valid && buf_rd.ready;
   assign is_ext = buf_rd.data == `KBH_CODE_EXT;
   assign is_rel = buf_rd.data == `KBH_CODE_REL;
   assign is_shift = buf_rd.data == `KBH_CODE_LSHIFT ||
                     buf_rd.data == `KBH_CODE_RSHIFT;
   assign trapped = is_shift && trap_q;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scan_q <= 8'h00;
         {shift_q, rel_q, ext_q} <= 3'h0;
         {seen_rel_q, seen_ext_q} <= 2'h0;
      end else if (drain) begin
         if (is_ext) begin
            ext_q <= 1'b1;
            seen_ext_q <= 1'b1;
         end else if (is_rel) begin
            rel_q <= 1'b1;
            seen_rel_q <= 1'b1;
         end else begin
            if (is_shift) shift_q <= !seen_rel_q;
            if (!trapped) begin
               scan_q <= buf_rd.data;
               ext_q <= seen_ext_q;
               rel_q <= seen_rel_q;
            end
            {seen_rel_q, seen_ext_q} <= 2'h0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // status flags and interrupt line
   // ----------------------------------------------------------------------
   always_comb begin
      tx_irq_d = tx_irq_q;
      if (sts_wr && PWDATA[`KBH_STS_TXIRQ_BIT]) tx_irq_d = 1'b0;
      if (tx_finish) tx_irq_d = 1'b1;
      rx_irq_d = rx_irq_q;
      if (sts_wr && PWDATA[`KBH_STS_RXIRQ_BIT]) rx_irq_d = 1'b0;
      if (drain && !is_ext && !is_rel && !trapped) rx_irq_d = 1'b1;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_irq_q <= 1'b0;
         rx_irq_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         tx_irq_q <= tx_irq_d;
         rx_irq_q <= rx_irq_d;
         irq_q <= tx_irq_d || rx_irq_d;
      end
   end

   assign PRDATA = prdata_q;
   assign IRQ = irq_q;
   assign KB_CLK_O = clk_o_q;
   assign KB_CLK_OE_N = clk_oe_n_q;
   assign KB_DAT_O = dat_o_q;
   assign KB_DAT_OE_N = dat_oe_n_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_err_with_done;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (st_q == kbh_pkg::TX_ACK && kclk_fall && kdat_f_q) |=>
         tx_err_q ##[1:1000] tx_irq_q;
   endproperty
   a_err_with_done: assert property (p_err_with_done)
      else $error("missing ack not flagged before completion");

   property p_err_cleared;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      tx_launch |=> !tx_err_q && st_q == kbh_pkg::TX_INHIBIT;
   endproperty
   a_err_cleared: assert property (p_err_cleared)
      else $error("error flag survived the next command start");

   property p_done_sets;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      tx_finish |=> tx_irq_q && !cmd_start_q && st_q == kbh_pkg::TX_IDLE;
   endproperty
   a_done_sets: assert property (p_done_sets)
      else $error("send completion not reported");

   property p_txirq_sticky;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (tx_irq_q && !(sts_wr && PWDATA[`KBH_STS_TXIRQ_BIT])) |=> tx_irq_q;
   endproperty
   a_txirq_sticky: assert property (p_txirq_sticky)
      else $error("transmit-complete flag dropped without a clear");

   property p_rx_report;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (drain && !is_ext && !is_rel && !trapped) |=>
         rx_irq_q && scan_q == $past(buf_rd.data);
   endproperty
   a_rx_report: assert property (p_rx_report)
      else $error("received byte not reported");

   property p_rx_clear;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (rx_irq_q && sts_wr && PWDATA[`KBH_STS_RXIRQ_BIT]) |=> !rx_irq_q;
   endproperty
   a_rx_clear: assert property (p_rx_clear)
      else $error("receive flag not cleared by write one");

   property p_prefix_quiet;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (drain && (is_ext || is_rel)) |=>
         !rx_irq_q && $stable(scan_q) && (ext_q || rel_q);
   endproperty
   a_prefix_quiet: assert property (p_prefix_quiet)
      else $error("prefix byte reported or lost");

   property p_trap_shift;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (drain && trapped) |=>
         !rx_irq_q && $stable(scan_q) && shift_q == !$past(seen_rel_q);
   endproperty
   a_trap_shift: assert property (p_trap_shift)
      else $error("trapped shift code was reported");

   property p_irq_line;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      ##1 IRQ == (rx_irq_q || tx_irq_q);
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt line disagrees with flags");

   c_send: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
      tx_finish && !tx_err_q);
   c_noack: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
      tx_finish && tx_err_q);
   c_release: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
      drain && is_rel ##[1:1000] drain && !is_ext && !is_rel);
endmodule

// File: testbench.sv
// register-level tests of the keyboard host
`include "kbh_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, pen, pwr, ko, kd, ko_n, kd_n, irq, cw, dw;
   logic [31:0] pa, pwd, prd;
   int err_total, total_checks;
   assign cw = kbd.clk_d & (ko_n | ko);
   assign dw = kbd.dat_d & (kd_n | kd);
   kbh_kbd_model kbd (.clk_w(cw), .dat_w(dw), .clk_d(), .dat_d());
   kbh_top DUT (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
      .PRDATA(prd), .IRQ(irq), .KB_CLK_I(cw), .KB_CLK_O(ko),
      .KB_CLK_OE_N(ko_n), .KB_DAT_I(dw), .KB_DAT_O(kd),
      .KB_DAT_OE_N(kd_n));
   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [31:0] a, d);
      @(posedge clk) #1;
      {psel, pwr, pa, pwd} = {1'b1, w, a, d};
      @(posedge clk) #1 pen = 1'b1;
      @(posedge clk) #1;
      {psel, pen} = 2'b00;
   endtask
   task automatic rd(input logic [31:0] a, e);
      acc(1'b0, a, 32'h0);
      chk(prd, e);
   endtask
   task automatic key(input logic [7:0] b);
      kbd.tx(b);
      repeat (12) @(posedge clk);
   endtask
   task automatic send(input logic [31:0] c, input logic ack);
      acc(1'b1, `KBH_CMD_ADDR, c);
      for (int i = 0; i < 2000 && kd_n; i++) @(posedge clk);
      kbd.rx(ack);
      repeat (12) @(posedge clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #3ms err_total++; // hang guard
      give_verdict();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      {rst_n, psel, pen, pwr, pa, pwd} = '0;
      {err_total, total_checks} = '0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(`KBH_STS_ADDR, `KBH_STS_RST);
      rd(`KBH_SCAN_ADDR, `KBH_SCAN_RST);
      rd(32'hfff8_9010, 32'h0);
      key(8'h1c);
      rd(`KBH_SCAN_ADDR, 32'h1c);
      rd(`KBH_STS_ADDR, 32'h1);
      chk(irq, 1'b1);
      key(8'h21);
      key(8'h22);
      key(8'h23);
      chk(ko_n, 1'b0); // full buffer and a waiting byte hold the keyboard off
      rd(`KBH_SCAN_ADDR, 32'h1c);
      fork
         key(8'h24);
      join_none
      for (int b = 8'h21; b < 8'h25; b++) begin
         acc(1'b1, `KBH_STS_ADDR, 32'h1);
         repeat (30) @(posedge clk);
         rd(`KBH_SCAN_ADDR, 32'(b));
      end
      acc(1'b1, `KBH_STS_ADDR, 32'h1);
      chk(irq, 1'b0);
      key(8'he0);
      rd(`KBH_SCAN_ADDR, 32'h124);
      rd(`KBH_STS_ADDR, 32'h0);
      key(8'h75);
      rd(`KBH_SCAN_ADDR, 32'h175);
      acc(1'b1, `KBH_STS_ADDR, 32'h1);
      key(8'hf0);
      key(8'h75);
      rd(`KBH_SCAN_ADDR, 32'h275);
      acc(1'b1, `KBH_STS_ADDR, 32'h1);
      key(8'h12);
      rd(`KBH_SCAN_ADDR, 32'h412);
      acc(1'b1, `KBH_STS_ADDR, 32'h1);
      key(8'hf0);
      key(8'h12);
      rd(`KBH_SCAN_ADDR, 32'h212);
      acc(1'b1, `KBH_STS_ADDR, 32'h1);
      acc(1'b1, `KBH_CMD_ADDR, 32'h200);
      key(8'h59);
      rd(`KBH_SCAN_ADDR, 32'h612);
      rd(`KBH_STS_ADDR, 32'h0);
      send(32'h1ed, 1'b1);
      chk(kbd.got, 8'hed);
      rd(`KBH_STS_ADDR, 32'h10);
      rd(`KBH_CMD_ADDR, 32'hed);
      acc(1'b1, `KBH_STS_ADDR, 32'h10);
      send(32'h1a5, 1'b0);
      acc(1'b1, `KBH_STS_ADDR, 32'h30);
      rd(`KBH_STS_ADDR, 32'h20);
      acc(1'b1, `KBH_CMD_ADDR, 32'h100);
      repeat (3) @(posedge clk);
      rd(`KBH_STS_ADDR, 32'h0);
      give_verdict();
   end
endmodule
